// *** verilog/mck_pkg.sv ***
// Constants and types for the machine check and checkstop unit.
package mck_pkg;
  // A documented bit n (numbered from the MSB) sits at vector index 31 - n.
  localparam int unsigned MSR_IP = 31 - 25;
  localparam int unsigned MSR_ILE = 31 - 15;
  localparam int unsigned MSR_ME = 31 - 19;
  localparam int unsigned MSR_LE = 31 - 31;
  localparam int unsigned HC_MCP_EN = 31 - 0;
  localparam int unsigned HC_AP_EN = 31 - 2;
  localparam int unsigned HC_DP_EN = 31 - 3;
  localparam int unsigned IC_IC_EN = 31 - 4;
  localparam int unsigned IC_DC_EN = 31 - 5;
  localparam int unsigned L2C_PE = 31 - 1;
  localparam int unsigned L2_MULTI = 31 - 0;
  localparam int unsigned L2_TAG = 31 - 27;
  localparam int unsigned L2_MB = 31 - 28;
  localparam int unsigned L2_SB = 31 - 29;
  localparam int unsigned MS_L2TAG = 31 - 13;
  localparam int unsigned MS_L2DAT = 31 - 14;
  localparam int unsigned MS_AP = 31 - 17;
  localparam int unsigned MS_DP = 31 - 18;
  localparam int unsigned MS_TEA = 31 - 19;
  localparam int unsigned S1_IC = 31 - 1;
  localparam int unsigned S1_DC = 31 - 2;
  localparam int unsigned S1_MSS = 31 - 11;
  localparam int unsigned S1_MCP = 31 - 12;
  localparam int unsigned S1_TEA = 31 - 13;
  localparam int unsigned S1_DP = 31 - 14;
  localparam int unsigned S1_AP = 31 - 15;
  localparam int unsigned S1_RI = 31 - 30;
  // Machine state bits 6, 16 to 29 and 31 that are saved on a take.
  localparam logic [31:0] S1_COPY_MASK = 32'h0200_FFFD;
  localparam logic [31:0] L2DET_MASK = 32'h8000_001C;
  localparam logic [31:0] MSSS_MASK = 32'h0006_F000;
  localparam logic [31:0] VEC_BASE_HI = 32'hFFF0_0000;
  localparam logic [31:0] VEC_BASE_LO = 32'h0000_0000;
  localparam logic [31:0] MC_OFFSET = 32'h0000_0200;
  // Register byte addresses on the bus.
  localparam logic [7:0] A_MSR = 8'h00;
  localparam logic [7:0] A_SAVE_RESTORE_ADDR = 8'h04;
  localparam logic [7:0] A_INTERRUPT_SAVE_STATUS = 8'h08;
  localparam logic [7:0] A_HW_CONFIG_ONE = 8'h0C;
  localparam logic [7:0] A_CACHE_INTERRUPT_CONTROL = 8'h10;
  localparam logic [7:0] A_L2_CONTROL = 8'h14;
  localparam logic [7:0] A_L2REN = 8'h18;
  localparam logic [7:0] A_L2DIS = 8'h1C;
  localparam logic [7:0] A_L2DET = 8'h20;
  localparam logic [7:0] A_MSSS = 8'h24;
  // Values after reset.
  localparam logic [31:0] RST_MSR = 32'h0000_0000;
  localparam logic [31:0] RST_HW_CONFIG_ONE = 32'h0000_0000;
  localparam logic [31:0] RST_CACHE_INTERRUPT_CONTROL = 32'h0000_0000;
  localparam logic [31:0] RST_L2_CONTROL = 32'h0000_0000;
  localparam logic [31:0] RST_L2REN = 32'h0000_001C;
  localparam logic [31:0] RST_L2DIS = 32'h0000_0000;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam int unsigned NCAUSE = 7;
  localparam int unsigned C_IC = 0;
  localparam int unsigned C_DC = 1;
  localparam int unsigned C_L2 = 2;
  localparam int unsigned C_MCP = 3;
  localparam int unsigned C_TEA = 4;
  localparam int unsigned C_DP = 5;
  localparam int unsigned C_AP = 6;
  typedef enum logic [2:0] {
    MCK_IDLE = 3'h1,
    MCK_QUIESCE = 3'h2,
    MCK_CKSTP = 3'h4
  } mck_state_t;
endpackage : mck_pkg

// *** verilog/mck_unit.sv ***
// Machine check collection, quiescing, interrupt take and checkstop logic.
`timescale 1ns/100ps
module mck_unit (
  input wire logic I_MCLK,
  input wire logic I_SRST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_BUS_TEA,
  input wire logic I_ADDR_PERR,
  input wire logic I_DATA_PERR,
  input wire logic I_IC_PERR,
  input wire logic I_DC_PERR,
  input wire logic I_L2_TAG_PERR,
  input wire logic I_L2_DATA_PERR,
  input wire logic I_L2_MBECC,
  input wire logic I_L2_SBECC,
  input wire logic I_MCHECK_N,
  input wire logic I_CKSTP_IN_N,
  input wire logic I_CORE_IDLE,
  input wire logic I_MEMSYS_IDLE,
  input wire logic I_STREAMS_STOPPED,
  input wire logic I_RECOVERABLE,
  input wire logic [31:0] I_CUR_EA,
  output logic O_QUIESCE_REQ,
  output logic O_STOP_STREAMS,
  output logic O_TAKE,
  output logic [31:0] O_VECTOR,
  output logic [31:0] O_MACHINE_STATE,
  output logic O_FREEZE,
  output logic O_CKSTP_OUT_N_O,
  output logic O_CKSTP_OUT_N_OE
);

  typedef struct packed {
    mck_pkg::mck_state_t fsm;
    logic mcp_s1;
    logic mcp_s2;
    logic mcp_s3;
    logic ck_s1;
    logic ck_s2;
    logic [31:0] machine_state;
    logic [31:0] save_restore_addr;
    logic [31:0] interrupt_save_status;
    logic [31:0] hw_config_one;
    logic [31:0] cache_interrupt_control;
    logic [31:0] l2_control;
    logic [31:0] l2ren;
    logic [31:0] l2dis;
    logic [31:0] l2det;
    logic [31:0] msss;
    logic [mck_pkg::NCAUSE-1:0] pend;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic take;
    logic [31:0] vector;
    logic freeze;
    logic ckstp_oe;
    logic quiesce;
  } mck_regs_t;

  mck_regs_t st;
  mck_regs_t next_st;

  logic mcp_evt;
  logic ap_evt;
  logic dp_evt;
  logic ic_evt;
  logic dc_evt;
  logic tea_evt;
  logic ecc_on;
  logic tag_evt;
  logic mb_evt;
  logic sb_evt;
  logic l2dp_evt;
  logic l2_evt;
  logic ckin;
  logic [2:0] l2_new;
  logic [mck_pkg::NCAUSE-1:0] new_c;

  // The pin is sampled only through the second and third stages.
  // Acting on the falling edge rather than the level means a pin that is
  // held low by a slow board does not retrigger the interrupt after the
  // handler sets the enable again; a user must pulse the pin for each event.
  assign mcp_evt = st.mcp_s3 & ~st.mcp_s2 & st.hw_config_one[mck_pkg::HC_MCP_EN];
  assign ckin = ~st.ck_s2;
  assign ap_evt = I_ADDR_PERR & st.hw_config_one[mck_pkg::HC_AP_EN];
  assign dp_evt = I_DATA_PERR & st.hw_config_one[mck_pkg::HC_DP_EN];
  assign ic_evt = I_IC_PERR & st.cache_interrupt_control[mck_pkg::IC_IC_EN];
  assign dc_evt = I_DC_PERR & st.cache_interrupt_control[mck_pkg::IC_DC_EN];
  // A transfer error has no enable and is never tied to one instruction.
  assign tea_evt = I_BUS_TEA;
  assign ecc_on = ~(st.l2dis[mck_pkg::L2_MB] & st.l2dis[mck_pkg::L2_SB]);
  assign l2dp_evt = I_L2_DATA_PERR & st.l2_control[mck_pkg::L2C_PE] & ~ecc_on;
  assign tag_evt = I_L2_TAG_PERR & st.l2ren[mck_pkg::L2_TAG]
                   & ~st.l2dis[mck_pkg::L2_TAG];
  assign mb_evt = I_L2_MBECC & st.l2ren[mck_pkg::L2_MB]
                  & ~st.l2dis[mck_pkg::L2_MB];
  assign sb_evt = I_L2_SBECC & st.l2ren[mck_pkg::L2_SB]
                  & ~st.l2dis[mck_pkg::L2_SB];
  assign l2_evt = tag_evt | mb_evt | sb_evt | l2dp_evt;
  assign l2_new = {tag_evt, mb_evt, sb_evt};

  always_comb
  begin
    new_c = '0;
    new_c[mck_pkg::C_IC] = ic_evt;
    new_c[mck_pkg::C_DC] = dc_evt;
    new_c[mck_pkg::C_L2] = l2_evt;
    new_c[mck_pkg::C_MCP] = mcp_evt;
    new_c[mck_pkg::C_TEA] = tea_evt;
    new_c[mck_pkg::C_DP] = dp_evt;
    new_c[mck_pkg::C_AP] = ap_evt;
  end

  always_comb
  begin
    logic setup;
    logic wr;
    logic hit;
    logic [31:0] rd;
    logic [31:0] cause;
    logic [2:0] old3;
    setup = I_PSEL & ~I_PENABLE;
    wr = I_PSEL & I_PENABLE & st.pready & I_PWRITE;
    hit = 1'b1;
    rd = mck_pkg::RST_ZERO;
    cause = mck_pkg::RST_ZERO;
    old3 = {st.l2det[mck_pkg::L2_TAG], st.l2det[mck_pkg::L2_MB],
            st.l2det[mck_pkg::L2_SB]};
    next_st = st;
    next_st.mcp_s1 = I_MCHECK_N;
    next_st.mcp_s2 = st.mcp_s1;
    next_st.mcp_s3 = st.mcp_s2;
    next_st.ck_s1 = I_CKSTP_IN_N;
    next_st.ck_s2 = st.ck_s1;
    next_st.take = 1'b0;

    // Read data is captured in the setup cycle, so the slave answers with no wait.
    case (I_PADDR)
      mck_pkg::A_MSR: rd = st.machine_state;
      mck_pkg::A_SAVE_RESTORE_ADDR: rd = st.save_restore_addr;
      mck_pkg::A_INTERRUPT_SAVE_STATUS: rd = st.interrupt_save_status;
      mck_pkg::A_HW_CONFIG_ONE: rd = st.hw_config_one;
      mck_pkg::A_CACHE_INTERRUPT_CONTROL: rd = st.cache_interrupt_control;
      mck_pkg::A_L2_CONTROL: rd = st.l2_control;
      mck_pkg::A_L2REN: rd = st.l2ren;
      mck_pkg::A_L2DIS: rd = st.l2dis;
      mck_pkg::A_L2DET: rd = st.l2det;
      mck_pkg::A_MSSS: rd = st.msss;
      default: hit = 1'b0;
    endcase
    next_st.pready = setup;
    if (setup)
    begin
      next_st.prdata = rd;
      next_st.pslverr = ~hit;
    end
    else if (st.pready)
    begin
      next_st.prdata = mck_pkg::RST_ZERO;
      next_st.pslverr = 1'b0;
    end

    // In checkstop every latch but the pin synchronizers holds; the bus still answers but writes are dropped.
    // Keeping reads alive lets a debugger pull the saved causes out of a
    // stopped core, which is worth more than a strictly frozen bus port.
    if (st.fsm != mck_pkg::MCK_CKSTP)
    begin
      if (wr)
      begin
        case (I_PADDR)
          mck_pkg::A_MSR: next_st.machine_state = I_PWDATA;
          mck_pkg::A_SAVE_RESTORE_ADDR: next_st.save_restore_addr = I_PWDATA;
          mck_pkg::A_INTERRUPT_SAVE_STATUS: next_st.interrupt_save_status = I_PWDATA;
          mck_pkg::A_HW_CONFIG_ONE: next_st.hw_config_one = I_PWDATA;
          mck_pkg::A_CACHE_INTERRUPT_CONTROL: next_st.cache_interrupt_control = I_PWDATA;
          mck_pkg::A_L2_CONTROL: next_st.l2_control = I_PWDATA;
          mck_pkg::A_L2REN: next_st.l2ren = I_PWDATA;
          mck_pkg::A_L2DIS: next_st.l2dis = I_PWDATA;
          mck_pkg::A_L2DET: next_st.l2det = st.l2det & ~I_PWDATA;
          mck_pkg::A_MSSS: next_st.msss = st.msss & ~I_PWDATA;
          default: next_st.machine_state = st.machine_state;
        endcase
      end
      // Flags are set after the clear so a same-cycle event is never lost.
      next_st.l2det[mck_pkg::L2_TAG] = next_st.l2det[mck_pkg::L2_TAG] | tag_evt;
      next_st.l2det[mck_pkg::L2_MB] = next_st.l2det[mck_pkg::L2_MB] | mb_evt;
      next_st.l2det[mck_pkg::L2_SB] = next_st.l2det[mck_pkg::L2_SB] | sb_evt;
      if ((|l2_new) && ((|old3) || ((l2_new & (l2_new - 3'h1)) != 3'h0)))
      begin
        next_st.l2det[mck_pkg::L2_MULTI] = 1'b1;
      end
      next_st.l2det = next_st.l2det & mck_pkg::L2DET_MASK;
      next_st.msss[mck_pkg::MS_L2TAG] = next_st.msss[mck_pkg::MS_L2TAG] | tag_evt;
      next_st.msss[mck_pkg::MS_L2DAT] = next_st.msss[mck_pkg::MS_L2DAT]
                                        | l2dp_evt | mb_evt | sb_evt;
      next_st.msss[mck_pkg::MS_AP] = next_st.msss[mck_pkg::MS_AP] | ap_evt;
      next_st.msss[mck_pkg::MS_DP] = next_st.msss[mck_pkg::MS_DP] | dp_evt;
      next_st.msss[mck_pkg::MS_TEA] = next_st.msss[mck_pkg::MS_TEA] | tea_evt;
      next_st.msss = next_st.msss & mck_pkg::MSSS_MASK;
      // Conditions stay pending until the take, collecting any that follow.
      next_st.pend = st.pend | new_c;
    end

    case (st.fsm)
      mck_pkg::MCK_IDLE:
      begin
        if (|next_st.pend)
        begin
          if (st.machine_state[mck_pkg::MSR_ME])
          begin
            next_st.fsm = mck_pkg::MCK_QUIESCE;
            next_st.quiesce = 1'b1;
          end
          else
          begin
            next_st.fsm = mck_pkg::MCK_CKSTP;
          end
        end
      end
      mck_pkg::MCK_QUIESCE:
      begin
        if (I_CORE_IDLE && I_MEMSYS_IDLE && I_STREAMS_STOPPED)
        begin
          cause[mck_pkg::S1_IC] = st.pend[mck_pkg::C_IC];
          cause[mck_pkg::S1_DC] = st.pend[mck_pkg::C_DC];
          cause[mck_pkg::S1_MSS] = st.pend[mck_pkg::C_L2];
          cause[mck_pkg::S1_MCP] = st.pend[mck_pkg::C_MCP];
          cause[mck_pkg::S1_TEA] = st.pend[mck_pkg::C_TEA];
          cause[mck_pkg::S1_DP] = st.pend[mck_pkg::C_DP];
          cause[mck_pkg::S1_AP] = st.pend[mck_pkg::C_AP];
          cause[mck_pkg::S1_RI] = I_RECOVERABLE;
          next_st.interrupt_save_status = (st.machine_state & mck_pkg::S1_COPY_MASK) | cause;
          next_st.save_restore_addr = I_CUR_EA;
          next_st.machine_state = mck_pkg::RST_ZERO;
          next_st.machine_state[mck_pkg::MSR_ILE] = st.machine_state[mck_pkg::MSR_ILE];
          next_st.machine_state[mck_pkg::MSR_IP] = st.machine_state[mck_pkg::MSR_IP];
          next_st.machine_state[mck_pkg::MSR_LE] = st.machine_state[mck_pkg::MSR_ILE];
          next_st.vector = (st.machine_state[mck_pkg::MSR_IP] ? mck_pkg::VEC_BASE_HI
                            : mck_pkg::VEC_BASE_LO) | mck_pkg::MC_OFFSET;
          // Only conditions seen this very cycle remain for the next round.
          next_st.pend = new_c;
          next_st.take = 1'b1;
          next_st.quiesce = 1'b0;
          next_st.fsm = mck_pkg::MCK_IDLE;
        end
      end
      mck_pkg::MCK_CKSTP:
      begin
        next_st.fsm = mck_pkg::MCK_CKSTP;
      end
      default:
      begin
        next_st.fsm = mck_pkg::MCK_IDLE;
      end
    endcase

    // The checkstop input wins over a take in flight, since the board has
    // already decided the system cannot continue.
    if (ckin)
    begin
      next_st.fsm = mck_pkg::MCK_CKSTP;
    end
    // Freeze and the output are set on the same edge as entry, well inside six cycles.
    if (next_st.fsm == mck_pkg::MCK_CKSTP)
    begin
      next_st.take = 1'b0;
      next_st.quiesce = 1'b0;
      next_st.freeze = 1'b1;
      next_st.ckstp_oe = 1'b1;
    end

    // Reset overrides everything, including checkstop, which only it may leave.
    if (I_SRST)
    begin
      next_st = '0;
      next_st.fsm = mck_pkg::MCK_IDLE;
      next_st.mcp_s1 = 1'b1;
      next_st.mcp_s2 = 1'b1;
      next_st.mcp_s3 = 1'b1;
      next_st.ck_s1 = 1'b1;
      next_st.ck_s2 = 1'b1;
      next_st.machine_state = mck_pkg::RST_MSR;
      next_st.hw_config_one = mck_pkg::RST_HW_CONFIG_ONE;
      next_st.cache_interrupt_control = mck_pkg::RST_CACHE_INTERRUPT_CONTROL;
      next_st.l2_control = mck_pkg::RST_L2_CONTROL;
      next_st.l2ren = mck_pkg::RST_L2REN;
      next_st.l2dis = mck_pkg::RST_L2DIS;
    end
  end

  always_ff @(posedge I_MCLK)
  begin
    st <= next_st;
  end

  assign O_PRDATA = st.prdata;
  assign O_PREADY = st.pready;
  assign O_PSLVERR = st.pslverr;
  assign O_QUIESCE_REQ = st.quiesce;
  assign O_STOP_STREAMS = st.quiesce;
  assign O_TAKE = st.take;
  assign O_VECTOR = st.vector;
  assign O_MACHINE_STATE = st.machine_state;
  assign O_FREEZE = st.freeze;
  // The open-drain pin only ever pulls low; the enable carries the state.
  assign O_CKSTP_OUT_N_O = 1'b0;
  assign O_CKSTP_OUT_N_OE = st.ckstp_oe;

endmodule : mck_unit

// *** tb/mck_unit_monitor.sv ***
// Concurrent checks on the ports of the machine check unit.
`timescale 1ns/100ps
module mck_unit_monitor (
  input wire logic I_MCLK,
  input wire logic I_SRST,
  input wire logic I_BUS_TEA,
  input wire logic I_CKSTP_IN_N,
  input wire logic I_CORE_IDLE,
  input wire logic I_MEMSYS_IDLE,
  input wire logic I_STREAMS_STOPPED,
  input wire logic O_QUIESCE_REQ,
  input wire logic O_STOP_STREAMS,
  input wire logic O_TAKE,
  input wire logic [31:0] O_VECTOR,
  input wire logic [31:0] O_MACHINE_STATE,
  input wire logic O_FREEZE,
  input wire logic O_CKSTP_OUT_N_O,
  input wire logic O_CKSTP_OUT_N_OE
);
  localparam logic [31:0] KEEP = (32'h1 << mck_pkg::MSR_IP) | (32'h1 << mck_pkg::MSR_ILE)
    | (32'h1 << mck_pkg::MSR_LE);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_SRST);
  a_me_set_quiesce: assert property (
    I_BUS_TEA && O_MACHINE_STATE[mck_pkg::MSR_ME] && !O_QUIESCE_REQ && !O_CKSTP_OUT_N_OE
    && !O_TAKE |=> O_QUIESCE_REQ) else $error("transfer error did not start quiescing");
  a_me_clr_ckstp: assert property (
    I_BUS_TEA && !O_MACHINE_STATE[mck_pkg::MSR_ME] |-> ##[1:2] O_CKSTP_OUT_N_OE)
    else $error("error with enable clear did not checkstop");
  a_take_quiet: assert property (
    $rose(O_TAKE) |-> $past(O_QUIESCE_REQ && I_CORE_IDLE && I_MEMSYS_IDLE && I_STREAMS_STOPPED))
    else $error("take before quiesce completed");
  a_stop_streams: assert property (
    O_QUIESCE_REQ |-> O_STOP_STREAMS) else $error("streams not stopped while quiescing");
  a_take_state: assert property (
    O_TAKE |-> (O_MACHINE_STATE & ~KEEP) == 32'h0000_0000
    && O_MACHINE_STATE[mck_pkg::MSR_LE] == O_MACHINE_STATE[mck_pkg::MSR_ILE])
    else $error("machine state wrong at take");
  a_take_vector: assert property (
    O_TAKE |-> O_VECTOR == ((O_MACHINE_STATE[mck_pkg::MSR_IP] ? mck_pkg::VEC_BASE_HI
    : mck_pkg::VEC_BASE_LO) | mck_pkg::MC_OFFSET)) else $error("handler vector wrong");
  a_freeze_hold: assert property (
    O_FREEZE |=> O_FREEZE && !O_TAKE) else $error("checkstop left without reset");
  a_freeze_soon: assert property (
    $rose(O_CKSTP_OUT_N_OE) |-> ##[0:6] O_FREEZE) else $error("latches not frozen in time");
  a_pin_drive: assert property (
    O_CKSTP_OUT_N_OE |-> !O_CKSTP_OUT_N_O) else $error("checkstop pin not pulled low");
  a_ckstp_input: assert property (
    !I_CKSTP_IN_N [*3] |-> ##[0:4] O_CKSTP_OUT_N_OE) else $error("checkstop input ignored");
endmodule : mck_unit_monitor

bind mck_unit mck_unit_monitor u_mon (.I_MCLK(I_MCLK), .I_SRST(I_SRST),
  .I_BUS_TEA(I_BUS_TEA), .I_CKSTP_IN_N(I_CKSTP_IN_N), .I_CORE_IDLE(I_CORE_IDLE),
  .I_MEMSYS_IDLE(I_MEMSYS_IDLE), .I_STREAMS_STOPPED(I_STREAMS_STOPPED),
  .O_QUIESCE_REQ(O_QUIESCE_REQ), .O_STOP_STREAMS(O_STOP_STREAMS), .O_TAKE(O_TAKE),
  .O_VECTOR(O_VECTOR), .O_MACHINE_STATE(O_MACHINE_STATE), .O_FREEZE(O_FREEZE),
  .O_CKSTP_OUT_N_O(O_CKSTP_OUT_N_O), .O_CKSTP_OUT_N_OE(O_CKSTP_OUT_N_OE));

// *** tb/mck_far.sv ***
// Far-side model: quiesce acknowledgements and bus transfer errors.
`timescale 1ns/100ps
module mck_far (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_quiesce,
  input wire logic i_stop,
  input wire logic i_slow,
  input wire logic i_tea_req,
  output logic o_core_idle,
  output logic o_mem_idle,
  output logic o_streams_off,
  output logic o_tea
);
  logic [3:0] cnt;
  always_ff @(posedge i_clk)
  begin
    if (i_rst || !i_quiesce)
    begin
      cnt <= 4'h0;
    end
    else if (cnt != 4'hF)
    begin
      cnt <= cnt + 4'h1;
    end
    o_tea <= i_tea_req && !i_rst;
  end
  // The memory side drains last, so a take ahead of it would be premature.
  assign o_core_idle = i_quiesce && cnt >= 4'h1;
  assign o_mem_idle = i_quiesce && cnt >= (i_slow ? 4'h9 : 4'h2);
  assign o_streams_off = i_stop && cnt >= (i_slow ? 4'h5 : 4'h1);
endmodule : mck_far

// *** tb/test_mck_unit.sv ***
// Self-checking testbench for the machine check unit.
`timescale 1ns/100ps
module test_mck_unit;
  localparam logic [31:0] EA = 32'h0000_4A5C;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
  logic [7:0] paddr = 8'h00, err = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, r, msrv, keepv;
  logic mcheck_n = 1'b1, ckstp_n = 1'b1, slow = 1'b0, tea_req = 1'b0;
  logic [31:0] prdata, vector, mstate;
  logic pready, pslverr, tea, cidle, midle, soff, quiesce, stop, take, freeze, ck_o, ck_oe;
  logic ck_pin;
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  // The checkstop line is open drain with a pull-up.
  assign ck_pin = ck_oe ? ck_o : 1'b1;
  always #4 clk = ~clk;
  mck_unit dut (.I_MCLK(clk), .I_SRST(srst), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_BUS_TEA(tea), .I_ADDR_PERR(err[0]),
    .I_DATA_PERR(err[1]), .I_IC_PERR(err[2]), .I_DC_PERR(err[3]), .I_L2_TAG_PERR(err[4]),
    .I_L2_DATA_PERR(err[5]), .I_L2_MBECC(err[6]), .I_L2_SBECC(err[7]), .I_MCHECK_N(mcheck_n),
    .I_CKSTP_IN_N(ckstp_n), .I_CORE_IDLE(cidle), .I_MEMSYS_IDLE(midle),
    .I_STREAMS_STOPPED(soff), .I_RECOVERABLE(1'b1), .I_CUR_EA(EA), .O_QUIESCE_REQ(quiesce),
    .O_STOP_STREAMS(stop), .O_TAKE(take), .O_VECTOR(vector), .O_MACHINE_STATE(mstate),
    .O_FREEZE(freeze), .O_CKSTP_OUT_N_O(ck_o), .O_CKSTP_OUT_N_OE(ck_oe));
  mck_far far (.i_clk(clk), .i_rst(srst), .i_quiesce(quiesce), .i_stop(stop),
    .i_slow(slow), .i_tea_req(tea_req), .o_core_idle(cidle), .o_mem_idle(midle),
    .o_streams_off(soff), .o_tea(tea));
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
    begin
      $display("Simulation passed");
    end
    else
    begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(r, exp);
  endtask : rd
  // Bits 7:0 of m pulse the error inputs, bit 8 asks for a transfer error, bit 9 the pin.
  task automatic fire(input logic [9:0] m);
    slow <= ~slow;
    err <= m[7:0];
    tea_req <= m[8];
    mcheck_n <= ~m[9];
    @(posedge clk);
    err <= 8'h00;
    tea_req <= 1'b0;
    mcheck_n <= 1'b1;
  endtask : fire
  task automatic round(input logic [9:0] m, input logic [31:0] cause, input logic [31:0] ms);
    int n;
    n = 0;
    wr(mck_pkg::A_MSR, msrv);
    fire(m);
    while (take !== 1'b1 && n < 60)
    begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, take}, 32'h1);
    chk(vector, mck_pkg::VEC_BASE_HI | mck_pkg::MC_OFFSET);
    rd(mck_pkg::A_MSR, keepv);
    rd(mck_pkg::A_INTERRUPT_SAVE_STATUS, cause | (msrv & mck_pkg::S1_COPY_MASK) | 32'h2);
    rd(mck_pkg::A_SAVE_RESTORE_ADDR, EA);
    rd(mck_pkg::A_MSSS, ms);
    wr(mck_pkg::A_MSSS, ms);
    rd(mck_pkg::A_MSSS, 32'h0000_0000);
  endtask : round
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      report_and_stop();
    end
  end
  initial
  begin
    msrv = 32'h0208_0000 >> 6 | 32'h0200_0000 >> 19 | 32'h0000_1000;
    msrv = (32'h1 << mck_pkg::MSR_ME) | (32'h1 << mck_pkg::MSR_IP) | (32'h1 << mck_pkg::MSR_ILE);
    keepv = (32'h1 << mck_pkg::MSR_IP) | (32'h1 << mck_pkg::MSR_ILE) | 32'h1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(mck_pkg::A_L2REN, mck_pkg::RST_L2REN);
    rd(mck_pkg::A_HW_CONFIG_ONE, mck_pkg::RST_HW_CONFIG_ONE);
    apb(1'b0, 8'h28, 32'h0000_0000);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0000_0000);
    wr(mck_pkg::A_MSR, msrv);
    wr(mck_pkg::A_L2REN, 32'h0000_0000);
    fire(10'h211);
    repeat (6) @(posedge clk);
    chk({31'h0, quiesce}, 32'h0);
    rd(mck_pkg::A_MSSS, 32'h0000_0000);
    rd(mck_pkg::A_L2DET, 32'h0000_0000);
    wr(mck_pkg::A_HW_CONFIG_ONE, 32'hB000_0000);
    wr(mck_pkg::A_CACHE_INTERRUPT_CONTROL, 32'h0C00_0000);
    wr(mck_pkg::A_L2REN, mck_pkg::RST_L2REN);
    round(10'h002, 32'h1 << mck_pkg::S1_DP, 32'h1 << mck_pkg::MS_DP);
    round(10'h001, 32'h1 << mck_pkg::S1_AP, 32'h1 << mck_pkg::MS_AP);
    round(10'h00C, 32'h6000_0000, 32'h0);
    round(10'h100, 32'h1 << mck_pkg::S1_TEA, 32'h1 << mck_pkg::MS_TEA);
    round(10'h200, 32'h1 << mck_pkg::S1_MCP, 32'h0);
    round(10'h010, 32'h1 << mck_pkg::S1_MSS, 32'h1 << mck_pkg::MS_L2TAG);
    rd(mck_pkg::A_L2DET, 32'h1 << mck_pkg::L2_TAG);
    wr(mck_pkg::A_L2DET, 32'h1 << mck_pkg::L2_TAG);
    rd(mck_pkg::A_L2DET, 32'h0000_0000);
    round(10'h0C0, 32'h1 << mck_pkg::S1_MSS, 32'h1 << mck_pkg::MS_L2DAT);
    rd(mck_pkg::A_L2DET, 32'h8000_000C);
    wr(mck_pkg::A_L2DET, mck_pkg::L2DET_MASK);
    rd(mck_pkg::A_L2DET, 32'h0000_0000);
    wr(mck_pkg::A_L2DIS, 32'h0000_000C);
    wr(mck_pkg::A_L2_CONTROL, 32'h4000_0000);
    round(10'h020, 32'h1 << mck_pkg::S1_MSS, 32'h1 << mck_pkg::MS_L2DAT);
    fire(10'h100);
    repeat (8) @(posedge clk);
    chk({30'h0, ck_pin, freeze}, 32'h1);
    wr(mck_pkg::A_MSR, msrv);
    rd(mck_pkg::A_MSR, keepv);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    chk({30'h0, ck_pin, freeze}, 32'h2);
    ckstp_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk({30'h0, ck_pin, freeze}, 32'h1);
    report_and_stop();
  end
endmodule : test_mck_unit
